// ### logic/bsl_loader.sv
`timescale 1ns/1ps
//
// Contract
// - spi clock is core clock divided by 160
// - send read command, 24-bit zero address
// - spi mode 0, idle low, rising sample
// - image bytes assembled first bit as lsb
// - spi boot pins fixed, not configurable
// - enable link about 200 ns after start
// - link enable: pulldowns off, outputs low, listen
// - ack word, image, end, reply end, jump
// - secure boot reads otp from word zero
// - bit 0 blocks test port access
// - bit 1 denies switch access to state
// - bit 5 forces otp boot, overrides source
// - bits 8..11 lock otp sectors 0..3
// - bit 12 locks all otp programming
// - bit 13 blocks test port otp access
// - bit 14 disables external debug request
// - general field 21:15, user id 31:22
// - load security word at power-up first
// - otp is four sectors of 512 words
// - otp programmed via address, data, control ports
// - image is count, words, crc, lsb first
// - reflected crc, preset ones, inverted residue
module bsl_loader import bsl_pkg::*; #(
  parameter int unsigned SPI_DIV = SPI_DIV_RATIO,
  parameter int unsigned RAM_AW = RAM_AW_DEF
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_mosi,
  input wire logic spi_miso,
  output logic link_out_wire_0,
  output logic link_out_wire_1,
  output logic link_out_oe,
  output logic link_pd_en,
  input wire logic link_in_wire_0,
  input wire logic link_in_wire_1,
  output logic ram_we,
  output logic [RAM_AW-1:0] ram_addr,
  output logic [31:0] ram_wdata,
  output logic boot_jump,
  output logic boot_fail,
  output logic test_port_block,
  output logic switch_access_deny,
  output logic tp_otp_block,
  input wire logic debug_req_n,
  output logic debug_req_eff_n
);

  if (SPI_DIV < 2 || SPI_DIV % 2 != 0 || SPI_DIV > 512) begin : g_div_chk
    $error("SPI_DIV must be even and within 2..512");
  end
  if (RAM_AW < 2 || RAM_AW > 30) begin : g_aw_chk
    $error("RAM_AW must lie within 2..30");
  end

  localparam logic [8:0] SPI_HALF = 9'(SPI_DIV / 2);
  localparam logic [7:0] DLY_LAST = 8'(LINK_DLY_CYC - 1);
  localparam logic [31:0] RAM_WORDS = 32'(1) << RAM_AW;

  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r >> 1) ^ ((r[0] ^ b[i]) ? CRC_POLY : 32'h00000000);
    end
    return r;
  endfunction : crc_byte

  ////////////////////////////////////////////////////////////////////////////////
  // state
  bsl_state_e state_q;
  bsl_state_e prev_q;
  bsl_src_e src_q;
  bsl_phase_e ph_q;
  logic [31:0] sec_q;
  logic [1:0] bidx_q;
  logic [31:0] wd_q;
  logic [31:0] nwords_q;
  logic [31:0] wcnt_q;
  logic [31:0] crc_q;
  logic [31:0] ack_dest_q;
  logic [7:0] dly_q;
  logic link_en_q;
  logic ltx_go_q;
  logic start_q;
  bsl_src_e ctrl_src_q;
  // otp
  // blank fuses read as zero, so a fresh part loads an all-clear security word
  logic [31:0] otp_mem [0:OTP_WORDS] = '{default: 32'h00000000};
  logic [15:0] otp_addr_q;
  logic [31:0] otp_wdata_q;
  logic [31:0] otp_rdata_q;
  logic [10:0] otp_ptr_q;
  logic [1:0] otp_bsel_q;
  // spi
  logic [8:0] div_q;
  logic [31:0] spi_tx_q;
  logic [5:0] rise_n_q;
  logic [7:0] spi_rx_q;
  logic [2:0] spi_bit_q;
  logic spi_bv_q;
  logic [7:0] spi_byte_q;
  // link
  logic lin0_q;
  logic lin1_q;
  logic [8:0] lrx_sh_q;
  logic [3:0] lrx_n_q;
  logic lrx_tv_q;
  logic [8:0] lrx_tok_q;
  logic [8:0] ltx_sh_q;
  logic [3:0] ltx_cnt_q;

  logic src_vld;
  logic [7:0] src_byte;
  logic src_ctl;
  logic [31:0] wd_nxt;
  logic [31:0] otp_word;
  logic spi_tick;
  logic [1:0] prog_sector;
  logic prog_ok;
  logic secprog_ok;
  logic otpc_wr;
  logic lrx_t0;
  logic lrx_t1;

  assign spi_tick = div_q == SPI_HALF - 9'h001;
  assign otp_word = otp_mem[otp_ptr_q];
  assign wd_nxt = {src_byte, wd_q[31:8]};
  assign otpc_wr = reg_wr && reg_addr == REG_OTP_CTRL;
  assign prog_sector = otp_addr_q[10:9];
  assign prog_ok = otpc_wr && reg_wdata[OTPC_PROG] && otp_addr_q[15:11] == 5'h00
                   && !sec_q[SEC_MLOCK] && !sec_q[SEC_LOCK0 + 32'(prog_sector)];
  assign secprog_ok = otpc_wr && reg_wdata[OTPC_SECPROG] && !sec_q[SEC_MLOCK];
  assign lrx_t0 = link_in_wire_0 ^ lin0_q;
  assign lrx_t1 = link_in_wire_1 ^ lin1_q;

  always_comb begin
    src_vld = 1'b0;
    src_byte = 8'h00;
    src_ctl = 1'b0;
    case (src_q)
      SRC_SPI: begin
        src_vld = spi_bv_q;
        src_byte = spi_byte_q;
      end
      SRC_LINK: begin
        src_vld = lrx_tv_q;
        src_byte = lrx_tok_q[7:0];
        src_ctl = lrx_tok_q[8];
      end
      SRC_OTP: begin
        src_vld = state_q == ST_IMG;
        src_byte = otp_word[8*otp_bsel_q +: 8];
      end
      default: begin
        src_vld = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register port
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      start_q <= 1'b0;
      ctrl_src_q <= SRC_SPI;
      otp_addr_q <= 16'h0000;
      otp_wdata_q <= 32'h00000000;
    end else begin
      start_q <= reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_START];
      if (reg_wr && reg_addr == REG_CTRL) begin
        ctrl_src_q <= bsl_src_e'(reg_wdata[CTRL_SRC_LO +: 2]);
      end
      if (reg_wr && reg_addr == REG_OTP_ADDR) begin
        otp_addr_q <= reg_wdata[15:0];
      end
      if (reg_wr && reg_addr == REG_OTP_WDATA) begin
        otp_wdata_q <= reg_wdata;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_SEC: reg_rdata <= sec_q;
        REG_CTRL: reg_rdata <= {29'h00000000, ctrl_src_q, 1'b0};
        REG_STATUS: reg_rdata <= {22'h000000, link_en_q, boot_fail, state_q == ST_DONE,
                                  state_q inside {ST_ACK, ST_IMG, ST_ENDRX, ST_ENDTX},
                                  src_q, state_q};
        REG_OTP_ADDR: reg_rdata <= {16'h0000, otp_addr_q};
        REG_OTP_WDATA: reg_rdata <= otp_wdata_q;
        REG_OTP_RDATA: reg_rdata <= otp_rdata_q;
        REG_ACK_DEST: reg_rdata <= ack_dest_q;
        REG_WORDS: reg_rdata <= nwords_q;
        default: reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // otp array and security word; the array keeps its contents across reset
  always_ff @(posedge clk) begin
    if (prog_ok) begin
      otp_mem[otp_addr_q[10:0]] <= otp_wdata_q;
    end
    if (secprog_ok) begin
      otp_mem[OTP_SEC_ROW] <= otp_wdata_q;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      otp_rdata_q <= 32'h00000000;
    end else if (otpc_wr && reg_wdata[OTPC_READ]) begin
      otp_rdata_q <= otp_mem[otp_addr_q[10:0]];
    end
  end

  // gp field is writable by software; fused bits only change through reload
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sec_q <= 32'h00000000;
    end else if (state_q == ST_SECLD) begin
      sec_q <= otp_mem[OTP_SEC_ROW];
    end else if (reg_wr && reg_addr == REG_SEC) begin
      sec_q[SEC_GP_HI:SEC_GP_LO] <= reg_wdata[SEC_GP_HI:SEC_GP_LO];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      test_port_block <= 1'b1;
      switch_access_deny <= 1'b1;
      tp_otp_block <= 1'b1;
      debug_req_eff_n <= 1'b1;
    end else begin
      test_port_block <= sec_q[SEC_TP_OFF];
      switch_access_deny <= sec_q[SEC_SW_DENY];
      tp_otp_block <= sec_q[SEC_TP_OTP];
      debug_req_eff_n <= debug_req_n | sec_q[SEC_DBG_OFF];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // boot sequencer and image parser
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_RST;
      src_q <= SRC_SPI;
      ph_q <= PH_CNT;
      bidx_q <= 2'h0;
      wd_q <= 32'h00000000;
      nwords_q <= 32'h00000000;
      wcnt_q <= 32'h00000000;
      crc_q <= CRC_INIT;
      ack_dest_q <= 32'h00000000;
      dly_q <= 8'h00;
      link_en_q <= 1'b0;
      ltx_go_q <= 1'b0;
      ram_we <= 1'b0;
      ram_addr <= '0;
      ram_wdata <= 32'h00000000;
    end else begin
      ram_we <= 1'b0;
      ltx_go_q <= 1'b0;
      case (state_q)
        ST_RST: state_q <= ST_SECLD;
        ST_SECLD: state_q <= ST_IDLE;
        ST_IDLE: begin
          if (start_q) begin
            ph_q <= PH_CNT;
            bidx_q <= 2'h0;
            crc_q <= CRC_INIT;
            wcnt_q <= 32'h00000000;
            dly_q <= 8'h00;
            if (sec_q[SEC_SECURE]) begin
              src_q <= SRC_OTP;
              state_q <= ST_IMG;
            end else begin
              src_q <= ctrl_src_q;
              state_q <= ctrl_src_q == SRC_LINK ? ST_WAIT : ST_IMG;
            end
          end
        end
        ST_WAIT: begin
          dly_q <= dly_q + 8'h01;
          if (dly_q == DLY_LAST) begin
            link_en_q <= 1'b1;
            state_q <= ST_ACK;
          end
        end
        ST_ACK: begin
          if (src_vld) begin
            bidx_q <= bidx_q + 2'h1;
            wd_q <= wd_nxt;
            if (src_ctl) begin
              state_q <= ST_FAIL;
            end else if (bidx_q == 2'h3) begin
              ack_dest_q <= wd_nxt;
              state_q <= ST_IMG;
            end
          end
        end
        ST_IMG: begin
          if (src_vld && src_ctl) begin
            state_q <= ST_FAIL;
          end else if (src_vld) begin
            bidx_q <= bidx_q + 2'h1;
            wd_q <= wd_nxt;
            if (ph_q != PH_CRC) begin
              crc_q <= crc_byte(crc_q, src_byte);
            end
            if (bidx_q == 2'h3) begin
              case (ph_q)
                PH_CNT: begin
                  nwords_q <= wd_nxt;
                  if (wd_nxt > RAM_WORDS) begin
                    state_q <= ST_FAIL;
                  end
                  ph_q <= wd_nxt == 32'h00000000 ? PH_CRC : PH_PROG;
                end
                PH_PROG: begin
                  ram_we <= 1'b1;
                  ram_addr <= wcnt_q[RAM_AW-1:0];
                  ram_wdata <= wd_nxt;
                  wcnt_q <= wcnt_q + 32'h00000001;
                  if (wcnt_q + 32'h00000001 == nwords_q) begin
                    ph_q <= PH_CRC;
                  end
                end
                default: begin
                  if (wd_nxt == ~crc_q || wd_nxt == CRC_SKIP) begin
                    state_q <= src_q == SRC_LINK ? ST_ENDRX : ST_DONE;
                  end else begin
                    state_q <= ST_FAIL;
                  end
                end
              endcase
            end
          end
        end
        ST_ENDRX: begin
          if (src_vld) begin
            if (src_ctl && src_byte == END_TOKEN) begin
              if (ack_dest_q == NULL_CHANEND) begin
                state_q <= ST_DONE;
              end else begin
                ltx_go_q <= 1'b1;
                state_q <= ST_ENDTX;
              end
            end else begin
              state_q <= ST_FAIL;
            end
          end
        end
        ST_ENDTX: begin
          if (ltx_cnt_q == 4'h1) begin
            state_q <= ST_DONE;
          end
        end
        ST_DONE: state_q <= ST_DONE;
        ST_FAIL: state_q <= ST_FAIL;
        default: state_q <= ST_FAIL;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prev_q <= ST_RST;
      boot_jump <= 1'b0;
      boot_fail <= 1'b0;
    end else begin
      prev_q <= state_q;
      boot_jump <= state_q == ST_DONE && prev_q != ST_DONE;
      boot_fail <= state_q == ST_FAIL;
    end
  end

  // otp byte source walks words from address zero, low byte first
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      otp_ptr_q <= 11'h000;
      otp_bsel_q <= 2'h0;
    end else if (state_q == ST_IDLE) begin
      otp_ptr_q <= 11'h000;
      otp_bsel_q <= 2'h0;
    end else if (src_q == SRC_OTP && state_q == ST_IMG) begin
      otp_bsel_q <= otp_bsel_q + 2'h1;
      if (otp_bsel_q == 2'h3) begin
        otp_ptr_q <= otp_ptr_q + 11'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // spi master on fixed pins; runs only while the image is still wanted
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_q <= 9'h000;
      spi_sclk <= 1'b0;
      spi_cs_n <= 1'b1;
      spi_mosi <= 1'b0;
      spi_tx_q <= 32'h00000000;
      rise_n_q <= 6'h00;
      spi_rx_q <= 8'h00;
      spi_bit_q <= 3'h0;
      spi_bv_q <= 1'b0;
      spi_byte_q <= 8'h00;
    end else begin
      spi_bv_q <= 1'b0;
      div_q <= spi_tick ? 9'h000 : div_q + 9'h001;
      if (state_q == ST_IDLE && start_q && !sec_q[SEC_SECURE] && ctrl_src_q == SRC_SPI) begin
        spi_cs_n <= 1'b0;
        spi_sclk <= 1'b0;
        div_q <= 9'h000;
        spi_tx_q <= {SPI_READ_CMD, SPI_START_ADDR};
        spi_mosi <= SPI_READ_CMD[7];
        rise_n_q <= 6'h00;
        spi_bit_q <= 3'h0;
      end else if (!spi_cs_n && spi_tick) begin
        if (!spi_sclk) begin
          if (src_q != SRC_SPI || state_q != ST_IMG) begin
            spi_cs_n <= 1'b1; // stop only with the clock low
          end else begin
            spi_sclk <= 1'b1;
            if (rise_n_q == 6'd32) begin
              spi_rx_q <= {spi_miso, spi_rx_q[7:1]};
              spi_bit_q <= spi_bit_q + 3'h1;
              if (spi_bit_q == 3'h7) begin
                spi_bv_q <= 1'b1;
                spi_byte_q <= {spi_miso, spi_rx_q[7:1]};
              end
            end else begin
              rise_n_q <= rise_n_q + 6'h01;
            end
          end
        end else begin
          spi_sclk <= 1'b0;
          spi_tx_q <= {spi_tx_q[30:0], 1'b0};
          spi_mosi <= spi_tx_q[30];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // boot link: a transition on wire 1 is a one, on wire 0 a zero
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lin0_q <= 1'b0;
      lin1_q <= 1'b0;
      lrx_sh_q <= 9'h000;
      lrx_n_q <= 4'h0;
      lrx_tv_q <= 1'b0;
      lrx_tok_q <= 9'h000;
    end else begin
      lin0_q <= link_in_wire_0;
      lin1_q <= link_in_wire_1;
      lrx_tv_q <= 1'b0;
      if (link_en_q && (lrx_t0 || lrx_t1)) begin
        lrx_sh_q <= {lrx_t1, lrx_sh_q[8:1]};
        if (lrx_n_q == TOKEN_BITS - 4'h1) begin
          lrx_n_q <= 4'h0;
          lrx_tv_q <= 1'b1;
          lrx_tok_q <= {lrx_t1, lrx_sh_q[8:1]};
        end else begin
          lrx_n_q <= lrx_n_q + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      link_out_wire_0 <= 1'b0;
      link_out_wire_1 <= 1'b0;
      link_out_oe <= 1'b0;
      link_pd_en <= 1'b1;
      ltx_sh_q <= 9'h000;
      ltx_cnt_q <= 4'h0;
    end else begin
      link_out_oe <= link_en_q;
      link_pd_en <= !link_en_q;
      if (ltx_go_q) begin
        ltx_sh_q <= {1'b1, END_TOKEN};
        ltx_cnt_q <= TOKEN_BITS;
      end else if (ltx_cnt_q != 4'h0) begin
        ltx_sh_q <= {1'b0, ltx_sh_q[8:1]};
        ltx_cnt_q <= ltx_cnt_q - 4'h1;
        if (ltx_sh_q[0]) begin
          link_out_wire_1 <= !link_out_wire_1;
        end else begin
          link_out_wire_0 <= !link_out_wire_0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic [8:0] hi_cnt_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hi_cnt_q <= 9'h000;
    end else begin
      hi_cnt_q <= spi_sclk ? hi_cnt_q + 9'h001 : 9'h000;
    end
  end

  spi_half_period_a: assert property ($fell(spi_sclk) |-> hi_cnt_q == SPI_HALF)
    else $error("spi clock high time wrong");
  spi_idle_low_a: assert property (spi_cs_n |-> !spi_sclk)
    else $error("spi clock not idle low");
  spi_cmd_first_a: assert property ($fell(spi_cs_n) |-> spi_mosi == SPI_READ_CMD[7])
    else $error("read command not first");
  secure_src_a: assert property ((state_q == ST_IDLE && start_q && sec_q[SEC_SECURE])
    |=> src_q == SRC_OTP && otp_ptr_q == 11'h000)
    else $error("secure boot not from otp zero");
  link_delay_a: assert property ($rose(state_q == ST_WAIT)
    |-> link_pd_en [*8] ##1 link_pd_en ##1 !link_pd_en)
    else $error("link enable delay wrong");
  otp_lock_a: assert property (otpc_wr && sec_q[SEC_LOCK0 + 32'(prog_sector)]
    |-> !prog_ok) else $error("locked otp programmed");
  master_lock_a: assert property (sec_q[SEC_MLOCK] |-> !prog_ok && !secprog_ok)
    else $error("master lock ignored");
  debug_off_a: assert property (sec_q[SEC_DBG_OFF] |=> debug_req_eff_n)
    else $error("debug request not disabled");
  test_block_a: assert property (sec_q[SEC_TP_OFF] && sec_q[SEC_TP_OTP]
    |=> test_port_block && tp_otp_block) else $error("test port not blocked");
  null_ack_a: assert property (state_q == ST_ENDTX |-> ack_dest_q != NULL_CHANEND)
    else $error("end sent to null channel end");
  link_init_a: assert property ($rose(link_en_q)
    |=> link_out_oe && !link_out_wire_0 && !link_out_wire_1)
    else $error("link outputs not low on enable");
  crc_fail_a: assert property ($rose(state_q == ST_FAIL) |=> boot_fail ##1 !boot_jump)
    else $error("failed boot not flagged");

  spi_boot_c: cover property ($rose(boot_jump) && src_q == SRC_SPI);
  link_boot_c: cover property ($rose(boot_jump) && src_q == SRC_LINK && prev_q == ST_ENDTX);
  otp_boot_c: cover property ($rose(boot_jump) && src_q == SRC_OTP);
  fail_c: cover property ($rose(boot_fail));

endmodule : bsl_loader

// ### logic/bsl_pkg.sv
package bsl_pkg;
  // clock and timing
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned CORE_REF_MHZ = 400;
  localparam int unsigned SPI_REF_KHZ = 2500;
  localparam int unsigned SPI_DIV_RATIO = CORE_REF_MHZ * 1000 / SPI_REF_KHZ;
  localparam int unsigned LINK_DLY_NS = 200;
  localparam int unsigned LINK_DLY_CYC = (LINK_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // spi flash access
  localparam logic [7:0] SPI_READ_CMD = 8'h03;
  localparam logic [23:0] SPI_START_ADDR = 24'h000000;
  // image and crc
  localparam logic [31:0] CRC_POLY = 32'hEDB88320;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_SKIP = 32'h0D15AB1E;
  localparam int unsigned RAM_AW_DEF = 14;
  // link tokens
  localparam logic [31:0] NULL_CHANEND = 32'h0000FF02;
  localparam logic [7:0] END_TOKEN = 8'h01;
  localparam logic [3:0] TOKEN_BITS = 4'h9;
  // otp layout
  localparam int unsigned OTP_SECTORS = 4;
  localparam int unsigned OTP_ROWS = 512;
  localparam int unsigned OTP_WORDS = OTP_SECTORS * OTP_ROWS;
  localparam int unsigned OTP_SEC_ROW = OTP_WORDS;
  // security configuration fields
  localparam int unsigned SEC_TP_OFF = 0;
  localparam int unsigned SEC_SW_DENY = 1;
  localparam int unsigned SEC_SECURE = 5;
  localparam int unsigned SEC_REDUND = 7;
  localparam int unsigned SEC_LOCK0 = 8;
  localparam int unsigned SEC_MLOCK = 12;
  localparam int unsigned SEC_TP_OTP = 13;
  localparam int unsigned SEC_DBG_OFF = 14;
  localparam int unsigned SEC_GP_LO = 15;
  localparam int unsigned SEC_GP_HI = 21;
  localparam int unsigned SEC_UID_LO = 22;
  // register byte offsets
  localparam logic [7:0] REG_SEC = 8'h00;
  localparam logic [7:0] REG_CTRL = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_OTP_ADDR = 8'h0C;
  localparam logic [7:0] REG_OTP_WDATA = 8'h10;
  localparam logic [7:0] REG_OTP_CTRL = 8'h14;
  localparam logic [7:0] REG_OTP_RDATA = 8'h18;
  localparam logic [7:0] REG_ACK_DEST = 8'h1C;
  localparam logic [7:0] REG_WORDS = 8'h20;
  // control bits
  localparam int unsigned CTRL_START = 0;
  localparam int unsigned CTRL_SRC_LO = 1;
  localparam int unsigned OTPC_PROG = 0;
  localparam int unsigned OTPC_SECPROG = 1;
  localparam int unsigned OTPC_READ = 2;

  typedef enum logic [1:0] {SRC_SPI = 2'h0, SRC_LINK = 2'h1, SRC_OTP = 2'h2} bsl_src_e;
  typedef enum logic [1:0] {PH_CNT = 2'h0, PH_PROG = 2'h1, PH_CRC = 2'h3} bsl_phase_e;
  typedef enum logic [3:0] {
    ST_RST = 4'h0, ST_SECLD = 4'h1, ST_IDLE = 4'h3, ST_WAIT = 4'h2, ST_ACK = 4'h6,
    ST_IMG = 4'h7, ST_ENDRX = 4'h5, ST_ENDTX = 4'h4, ST_DONE = 4'hC, ST_FAIL = 4'hD
  } bsl_state_e;
endpackage : bsl_pkg

// ### tb/bsl_flash_model.sv
`timescale 1ns/1ps
module bsl_flash_model (
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic [31:0] cmd
);
  // count 1, one word, skip marker; all least significant byte first
  logic [7:0] img [12] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h78, 8'h56, 8'h34, 8'h12,
    8'h1E, 8'hAB, 8'h15, 8'h0D};
  int cnt = 0;
  initial begin
    miso = 1'b0;
    cmd = '0;
  end
  always @(negedge cs_n) cnt = 0;
  always @(posedge sclk) begin
    if (!cs_n) begin
      if (cnt < 32) cmd = {cmd[30:0], mosi};
      cnt = cnt + 1;
    end
  end
  // no pull on the line, so outside the image bits the level toggles on each falling clock and at deselect
  always @(negedge sclk or posedge cs_n) begin
    if (cs_n || cnt < 32 || cnt >= 128) miso <= ~miso;
    else miso <= img[(cnt - 32) / 8][(cnt - 32) % 8];
  end
endmodule : bsl_flash_model

// ### tb/testbench.sv
`timescale 1ns/1ps
module testbench import bsl_pkg::*;;
  localparam logic [31:0] SEC = 32'h00006003;
  logic clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, debug_req_n = 0;
  logic [7:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0, reg_rdata, cmd, wd, d;
  logic [13:0] ram_addr, wa;
  logic spi_sclk, spi_cs_n, spi_mosi, spi_miso, ram_we, boot_jump, boot_fail;
  logic tpb, sad, tob, dbg, lo0, lo1, loe, lpd, lin0 = 0, lin1 = 0;
  logic [31:0] ram_wdata;
  int fails = 0, n_compared = 0, cyc = 0;
  always #12.5 clk = ~clk;
  bsl_loader #(.SPI_DIV(4)) DUT (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .link_out_wire_0(lo0), .link_out_wire_1(lo1), .link_out_oe(loe), .link_pd_en(lpd),
    .link_in_wire_0(lin0), .link_in_wire_1(lin1), .ram_we(ram_we), .ram_addr(ram_addr),
    .ram_wdata(ram_wdata), .boot_jump(boot_jump), .boot_fail(boot_fail),
    .test_port_block(tpb), .switch_access_deny(sad), .tp_otp_block(tob),
    .debug_req_n(debug_req_n), .debug_req_eff_n(dbg));
  bsl_flash_model flash (.sclk(spi_sclk), .cs_n(spi_cs_n), .mosi(spi_mosi),
    .miso(spi_miso), .cmd(cmd));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [31:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic do_reset();
    sys_rst <= 1'b1;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : do_reset
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////////////////////
  // security word comes from otp only after a fresh reset
  task automatic sec_scenario();
    chk("tp_block_off", 0, {31'h0, tpb});
    chk("dbg_eff_off", 0, {31'h0, dbg});
    wr(REG_OTP_WDATA, SEC);
    wr(REG_OTP_CTRL, 32'h1 << OTPC_SECPROG);
    do_reset();
    rd(REG_SEC);
    chk("sec", SEC, d);
    chk("tp_block", 1, {31'h0, tpb});
    chk("sw_deny", 1, {31'h0, sad});
    chk("tp_otp", 1, {31'h0, tob});
    chk("dbg_eff_n", 1, {31'h0, dbg});
    wr(REG_SEC, 32'hFFFFFFFF);
    rd(REG_SEC);
    chk("sec_gp", SEC | 32'h003F8000, d);
    rd(8'h40);
    chk("unmapped", 0, d);
  endtask : sec_scenario
  task automatic spi_boot();
    int n;
    n = 0;
    wa = '1;
    wd = '0;
    wr(REG_CTRL, 32'h1);
    while (boot_jump !== 1'b1 && n < 3000) begin
      @(posedge clk);
      #1;
      if (ram_we === 1'b1) begin
        wa = ram_addr;
        wd = ram_wdata;
      end
      n++;
    end
    chk("jump", 1, {31'h0, boot_jump});
    chk("cmd", {SPI_READ_CMD, SPI_START_ADDR}, cmd);
    chk("ram_addr", 0, {18'h0, wa});
    chk("ram_data", 32'h12345678, wd);
    chk("fail", 0, {31'h0, boot_fail});
    repeat (20) @(posedge clk);
    chk("sclk_idle", 0, {31'h0, spi_sclk});
  endtask : spi_boot
  task automatic send_tok(logic [8:0] t);
    for (int i = 0; i < 9; i++) begin
      @(posedge clk);
      if (t[i]) lin1 <= ~lin1;
      else lin0 <= ~lin0;
    end
  endtask : send_tok
  // peer side: ack word, empty image with skip marker, then end token
  task automatic link_boot(logic [31:0] ack);
    int n;
    logic [95:0] s;
    n = 0;
    s = {CRC_SKIP, 32'h00000000, ack};
    lin0 <= 1'b0;
    lin1 <= 1'b0;
    do_reset();
    wr(REG_CTRL, 32'h3);
    repeat (12) @(posedge clk);
    chk("pd_off", 0, {31'h0, lpd});
    chk("link_oe", 1, {31'h0, loe});
    chk("link_low", 0, {30'h0, lo1, lo0});
    for (int i = 0; i < 12; i++) begin
      send_tok({1'b0, s[8*i +: 8]});
    end
    send_tok({1'b1, END_TOKEN});
    while (boot_jump !== 1'b1 && n < 60) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("link_jump", 1, {31'h0, boot_jump});
    chk("end_reply", ack == NULL_CHANEND ? 32'h0 : 32'h1, {30'h0, lo1, lo0});
    rd(REG_ACK_DEST);
    chk("ack_dest", ack, d);
  endtask : link_boot
  task automatic otp_prog(logic [31:0] a, logic [31:0] v, logic [31:0] c);
    wr(REG_OTP_ADDR, a);
    wr(REG_OTP_WDATA, v);
    wr(REG_OTP_CTRL, c);
  endtask : otp_prog
  // secure bit forces otp boot although spi is selected; bad crc must fail
  task automatic otp_boot();
    int n;
    n = 0;
    wd = '0;
    otp_prog(0, 32'h1, 32'h1 << OTPC_PROG);
    otp_prog(1, 32'hA5A5A5A5, 32'h1 << OTPC_PROG);
    otp_prog(2, 32'h0, 32'h1 << OTPC_PROG);
    otp_prog(0, SEC | 32'h120, 32'h1 << OTPC_SECPROG);
    do_reset();
    otp_prog(0, 32'hFF, 32'h1 << OTPC_PROG);
    wr(REG_OTP_CTRL, 32'h1 << OTPC_READ);
    rd(REG_OTP_RDATA);
    chk("sector_lock", 1, d);
    wr(REG_CTRL, 32'h1);
    while (boot_fail !== 1'b1 && n < 100) begin
      @(posedge clk);
      #1;
      if (ram_we === 1'b1) wd = ram_wdata;
      n++;
    end
    chk("otp_word", 32'hA5A5A5A5, wd);
    chk("spi_unused", 1, {31'h0, spi_cs_n});
    rd(REG_STATUS);
    chk("otp_status", {23'h0, 1'b1, 2'h0, SRC_OTP, ST_FAIL}, d);
  endtask : otp_boot
  ////////////////////////////////////////////////////////////////////////////////
  // ample for every reset and boot below at the fast spi divider
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      fails++;
      conclude();
    end
  end
  initial begin
    do_reset();
    sec_scenario();
    spi_boot();
    link_boot(32'h00000005);
    link_boot(NULL_CHANEND);
    otp_boot();
    conclude();
  end
endmodule : testbench
